// *** hw/lpddr2_refresh_ctrl.sv ***
`default_nettype none
module lpddr2_refresh_ctrl
    import sref_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Command and address pins
    input wire cmd_bus_t cmd_in,
    // Power state
    output logic self_refresh_out,
    output logic power_down_out,
    output logic exit_busy_out,
    output logic clock_gated_out,
    // Refresh events
    output logic refab_out,
    output logic int_refresh_out
);
    power_state_t state;
    power_state_t next_state;
    logic cke_prev;
    logic [TIMER_W-1:0] xsr_count;
    logic [TIMER_W-1:0] next_xsr_count;
    logic timer_tick;
    logic timer_run;

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    wire logic cmd_sel = !cmd_in.cs_n && (cmd_in.ca[2:0] == CA_REFRESH_CODE);
    wire logic sref_cmd = cke_prev && !cmd_in.cke && cmd_sel;
    wire logic refab_cmd = cke_prev && cmd_in.cke && cmd_sel && cmd_in.ca[3];
    wire logic pdn_cmd = cke_prev && !cmd_in.cke && !cmd_sel;
    wire logic xsr_done = (xsr_count == TIMER_ZERO);

    // ----------------------------------------------------------------
    // Power state sequencing
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (sref_cmd) begin
                    next_state = ST_SREF;
                end else if (pdn_cmd) begin
                    next_state = ST_PDN;
                end
            end
            ST_SREF: begin
                // only CKE is looked at here
                if (cmd_in.cke) begin
                    next_state = ST_EXIT;
                end
            end
            ST_EXIT: begin
                if (sref_cmd) begin
                    next_state = ST_SREF;
                end else if (xsr_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_PDN: begin
                if (cmd_in.cke) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // tXSR counted from first edge seeing CKE high
    assign next_xsr_count = (state == ST_SREF) ? XSR_LOAD :
                            xsr_done ? TIMER_ZERO : xsr_count - TIMER_W'(1);

    // State and exit counter
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= ST_IDLE;
            cke_prev <= 1'b0;
            xsr_count <= TIMER_ZERO;
        end else begin
            state <= next_state;
            cke_prev <= cmd_in.cke;
            xsr_count <= next_xsr_count;
        end
    end

    // ----------------------------------------------------------------
    // Internal refresh timer
    // ----------------------------------------------------------------
    // timer runs from the entry edge through self refresh, never in power-down
    // Starting on the entry edge keeps the first refresh inside tCKESR
    assign timer_run = (next_state == ST_SREF);

    sref_timer refresh_timer (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .run_in(timer_run),
        .tick_out(timer_tick)
    );

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            self_refresh_out <= 1'b0;
            power_down_out <= 1'b0;
            exit_busy_out <= 1'b0;
            clock_gated_out <= 1'b0;
            refab_out <= 1'b0;
            int_refresh_out <= 1'b0;
        end else begin
            self_refresh_out <= (next_state == ST_SREF);
            power_down_out <= (next_state == ST_PDN);
            exit_busy_out <= (next_state == ST_EXIT);
            // clock gated off in self refresh
            clock_gated_out <= (next_state == ST_SREF);
            refab_out <= (state == ST_IDLE) && refab_cmd;
            int_refresh_out <= timer_tick;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    int exit_len;
    localparam int XSR_LEN = XSR_CYC;

    // Length of each exit period
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            exit_len <= 0;
        end else begin
            exit_len <= exit_busy_out ? exit_len + 1 : 0;
        end
    end

    a_sref_entry_taken: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (state == ST_IDLE && sref_cmd) |=> self_refresh_out && !power_down_out)
        else $error("self-refresh entry not taken");

    a_sref_stay_low: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (self_refresh_out && !cmd_in.cke) |=> self_refresh_out)
        else $error("left self refresh with CKE low");

    a_sref_inputs_ignored: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (self_refresh_out && !cmd_in.cke) |=> !refab_out && !exit_busy_out)
        else $error("input acted on during self refresh");

    a_clock_gate_match: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        clock_gated_out == self_refresh_out)
        else $error("clock gate does not follow self refresh");

    a_first_int_refresh: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        $rose(self_refresh_out) ##1 self_refresh_out[*2] |=> int_refresh_out)
        else $error("no internal refresh within tCKESR");

    a_exit_start_edge: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (self_refresh_out && cmd_in.cke) |=> exit_busy_out && !self_refresh_out)
        else $error("exit not started on first CKE high edge");

    a_exit_length: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        ($fell(exit_busy_out) && !self_refresh_out) |-> $past(exit_len) == XSR_LEN - 1)
        else $error("exit period length wrong");

    a_pdn_no_refresh: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        power_down_out ##1 power_down_out |-> !int_refresh_out)
        else $error("refresh during power-down");

    a_refab_decode: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (state == ST_IDLE && refab_cmd) |=> refab_out)
        else $error("all-bank refresh not decoded");
endmodule
`default_nettype wire

// *** hw/sref_pkg.sv ***
// Behaviour
// - Self-refresh entry is CKE low, CS_n low, CA 0/0/1, after CKE high.
// - CKE stays low during self refresh; device stays in self refresh while low.
// - In self refresh every input except CKE is ignored.
// - In self refresh the device refreshes on its own timer and gates its clock.
// - Device performs at least one internal all-bank refresh within tCKESR after entry.
// - tXSR counts from the first rising edge after CKE goes high.
// - No refresh happens in power-down; controller limits power-down length.
// - All-bank refresh decodes as CS_n low, CA 0/0/1/1 with CKE high.
`default_nettype none
package sref_pkg;
    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int T_REFI_PS = 7800000;
    localparam int T_CKESR_PS = 15000;
    localparam int T_XSR_PS = 140000;
    // Longest times round down, least times round up
    localparam int REFI_CYC = T_REFI_PS / CLK_PERIOD_PS;
    localparam int CKESR_CYC = T_CKESR_PS / CLK_PERIOD_PS;
    localparam int XSR_CYC = (T_XSR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TIMER_W = 12;
    localparam logic [TIMER_W-1:0] REFI_RELOAD = TIMER_W'(REFI_CYC - 1);
    localparam logic [TIMER_W-1:0] CKESR_LOAD = TIMER_W'(CKESR_CYC - 1);
    localparam logic [TIMER_W-1:0] XSR_LOAD = TIMER_W'(XSR_CYC - 1);
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 12'h000;

    // ----------------------------------------------------------------
    // Command bus
    // ----------------------------------------------------------------
    localparam int CA_W = 10;
    localparam logic [2:0] CA_REFRESH_CODE = 3'h4;  // CA2..CA0 = 1,0,0

    typedef struct packed {
        logic cke;
        logic cs_n;
        logic [CA_W-1:0] ca;
    } cmd_bus_t;

    // Gray coded along idle -> self refresh -> exit; exit -> idle flips both bits
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SREF = 2'h1,
        ST_EXIT = 2'h3,
        ST_PDN = 2'h2
    } power_state_t;
endpackage
`default_nettype wire

// *** hw/sref_timer.sv ***
`default_nettype none
module sref_timer
    import sref_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Control
    input wire logic run_in,
    // Internal refresh event
    output logic tick_out
);
    logic [TIMER_W-1:0] count;
    logic [TIMER_W-1:0] next_count;
    logic expired;

    // ----------------------------------------------------------------
    // Reload and expiry
    // ----------------------------------------------------------------
    assign expired = run_in && (count == TIMER_ZERO);
    assign next_count = !run_in ? CKESR_LOAD :
                        expired ? REFI_RELOAD : count - TIMER_W'(1);

    // Countdown, first expiry within tCKESR then every tREFI
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count <= CKESR_LOAD;
            tick_out <= 1'b0;
        end else begin
            count <= next_count;
            tick_out <= expired;
        end
    end
endmodule
`default_nettype wire

// *** test/sref_host.sv ***
`default_nettype none
module sref_host
    import sref_pkg::*;
(
    // Clock
    input wire logic clock_in,
    // Command and address pins
    output var cmd_bus_t cmd_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Refresh cycle time as a cycle count, plain default
    localparam int RFCAB_CYC = 33;
    // Four tRFCab apart keeps at most 8 refreshes per burst window
    // Runs are far shorter than one refresh window
    localparam int REF_GAP = 4 * RFCAB_CYC;
    // Cycles since the last all-bank refresh code was driven
    int since_ref = REF_GAP;

    // Idle pins: CKE high, no operation
    initial cmd_out = '{cke: 1'b1, cs_n: 1'b0, ca: 10'h3FF};

    // Drive one command from a falling edge for one full cycle
    task automatic issue(input logic cke, input logic cs_n, input logic [CA_W-1:0] ca);
        @(negedge clock_in);
        cmd_out <= '{cke: cke, cs_n: cs_n, ca: ca};
        // Restart the record on every all-bank refresh code driven with CKE high
        if (cke && !cs_n && (ca[3:0] == 4'hC)) begin
            since_ref = 0;
        end else begin
            since_ref++;
        end
    endtask

    task automatic nop(input logic cke);
        issue(cke, 1'b0, {since_ref[6:0], 3'h7});
    endtask

    // All-bank refresh code, spaced from the previous one
    task automatic refab();
        while (since_ref < REF_GAP) begin
            nop(1'b1);
        end
        issue(1'b1, 1'b0, {since_ref[5:0], 4'hC});
    endtask

    // Entry after a CKE-high cycle, then one no-operation
    task automatic sref_enter();
        nop(1'b1);
        issue(1'b0, 1'b0, 10'h004);
        nop(1'b0);
    endtask

    // CKE low; other pins toggle as they are don't-care
    task automatic sref_hold(input int k);
        issue(1'b0, k[1], k[0] ? 10'h00C : 10'h3F3);
    endtask

    // Two running cycles, then CKE high with a no-operation
    task automatic sref_exit();
        nop(1'b0);
        nop(1'b0);
        nop(1'b1);
    endtask
endmodule
`default_nettype wire

// *** test/testbench.sv ***
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock_in = 1'b0;
    logic nrst_in = 1'b0;
    sref_pkg::cmd_bus_t cmd;
    logic self_refresh_out, power_down_out, exit_busy_out;
    logic clock_gated_out, refab_out, int_refresh_out;
    int err_total = 0;
    int n_tests = 0;

    // 250 MHz clock
    always #2 clock_in = ~clock_in;

    sref_host u_sref_host (.clock_in(clock_in), .cmd_out(cmd));
    lpddr2_refresh_ctrl u_lpddr2_refresh_ctrl (.clock_in(clock_in), .nrst_in(nrst_in),
        .cmd_in(cmd), .self_refresh_out(self_refresh_out), .power_down_out(power_down_out),
        .exit_busy_out(exit_busy_out), .clock_gated_out(clock_gated_out),
        .refab_out(refab_out), .int_refresh_out(int_refresh_out));

    // ----------------------------------------------------------------
    // Compare and report
    // ----------------------------------------------------------------
    task automatic chk(input logic got, input logic exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    task automatic chk_n(input int got, input int exp, input string msg);
        n_tests++;
        if (got != exp) begin
            err_total++;
            $display("BAD %0t %s: %0d", $time, msg, got);
        end
    endtask

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_refab();
        u_sref_host.refab();
        u_sref_host.issue(1'b1, 1'b0, 10'h004);
        chk(refab_out, 1'b1, "first refresh lost");
        u_sref_host.nop(1'b1);
        chk(refab_out, 1'b0, "per-bank code taken");
        u_sref_host.refab();
        u_sref_host.nop(1'b1);
        chk(refab_out, 1'b1, "spaced refresh lost");
        $display("refresh test done");
    endtask

    task automatic t_sref();
        int pulses[$];
        int busy = 0;
        logic stray = 1'b0;
        logic left = 1'b0;
        // Entry follows the refreshes; a refresh follows the exit
        u_sref_host.sref_enter();
        chk(self_refresh_out, 1'b1, "no entry");
        chk(clock_gated_out, 1'b1, "clock not gated");
        for (int i = 1; i <= 1960; i++) begin
            u_sref_host.sref_hold(i);
            if (int_refresh_out === 1'b1) begin
                pulses.push_back(i);
            end
            stray |= (refab_out !== 1'b0);
            left |= (self_refresh_out !== 1'b1);
        end
        chk_n(pulses.size(), 2, "internal refresh count");
        chk_n(pulses[0], 3, "first internal refresh");
        chk_n(pulses[1] - pulses[0], sref_pkg::REFI_CYC, "internal period");
        chk(stray, 1'b0, "pins taken in self refresh");
        chk(left, 1'b0, "left self refresh with CKE low");
        u_sref_host.sref_exit();
        stray = 1'b0;
        for (int k = 1; k <= 40; k++) begin
            if (k == 10) u_sref_host.issue(1'b1, 1'b0, 10'h00C);
            else u_sref_host.nop(1'b1);
            busy += int'(exit_busy_out === 1'b1);
            stray |= (k <= 35) && (refab_out !== 1'b0);
        end
        chk_n(busy, sref_pkg::XSR_CYC, "exit period length");
        chk(stray, 1'b0, "refresh taken in exit");
        chk(self_refresh_out, 1'b0, "still in self refresh");
        u_sref_host.refab();
        u_sref_host.nop(1'b1);
        chk(refab_out, 1'b1, "refresh after exit lost");
        $display("self refresh test done");
    endtask

    task automatic t_pdn();
        int pulses = 0;
        u_sref_host.nop(1'b1);
        u_sref_host.issue(1'b0, 1'b1, 10'h3FF);
        u_sref_host.nop(1'b0);
        chk(power_down_out, 1'b1, "no power-down");
        chk(self_refresh_out, 1'b0, "power-down read as self refresh");
        for (int i = 0; i < 2100; i++) begin
            u_sref_host.nop(1'b0);
            pulses += int'(int_refresh_out === 1'b1);
        end
        chk_n(pulses, 0, "refresh in power-down");
        u_sref_host.nop(1'b1);
        u_sref_host.nop(1'b1);
        chk(power_down_out, 1'b0, "power-down not left");
        $display("power-down test done");
    endtask

    // Reset, then the scenarios in turn
    initial begin
        repeat (4) @(negedge clock_in);
        chk(|{self_refresh_out, power_down_out, exit_busy_out, clock_gated_out,
            refab_out, int_refresh_out}, 1'b0, "output active in reset");
        nrst_in = 1'b1;
        u_sref_host.nop(1'b1);
        u_sref_host.nop(1'b1);
        t_refab();
        t_sref();
        t_pdn();
        end_of_test();
    end

    // Watchdog against a hang
    initial begin
        #100000;
        err_total++;
        $display("BAD %0t watchdog expired", $time);
        end_of_test();
    end
endmodule
`default_nettype wire
